// file: hdl/dmcd_defines.svh
// Constants for the display mode command decoder.
`ifndef DMCD_DEFINES_SVH
`define DMCD_DEFINES_SVH

`define DMCD_ADDR_W        4
`define DMCD_OFS_CMD       4'h0
`define DMCD_OFS_PARAM     4'h4
`define DMCD_OFS_STATUS    4'h8
`define DMCD_OFS_AREA      4'hC

`define DMCD_CMD_SWRESET   8'h01
`define DMCD_CMD_PARTIAL   8'h12
`define DMCD_CMD_FULL      8'h13
`define DMCD_CMD_INV_CLR   8'h20
`define DMCD_CMD_INV_SET   8'h21
`define DMCD_CMD_AREA      8'h30

`define DMCD_PIX_W         18
`define DMCD_ROW_W         16
`define DMCD_AREA_START_RST 16'h0000
`define DMCD_AREA_END_RST  16'h00A1
`define DMCD_ZERO32        32'h0000_0000

`define DMCD_ST_PARTIAL    0
`define DMCD_ST_SCROLL     1
`define DMCD_ST_INVERT     2
`define DMCD_ST_PEND_PART  3
`define DMCD_ST_PEND_CHG   4
`define DMCD_AREA_END_LSB  16

`endif

// file: hdl/dmcd_pkg.sv
// Types shared by the display mode command decoder.
package dmcd_pkg;

	typedef enum logic [2:0] {
		DMCD_IDLE = 3'b000,
		DMCD_PA1  = 3'b001,
		DMCD_PA2  = 3'b011,
		DMCD_PA3  = 3'b010,
		DMCD_PA4  = 3'b110
	} dmcd_state_type;

	typedef struct packed {
		logic partial;
		logic scroll;
		logic invert;
	} dmcd_mode_type;

endpackage

// file: hdl/dmcd_top.sv
// Display mode command decoder with an Avalon-MM register slave.
`timescale 1ns/1ns

`include "dmcd_defines.svh"

module dmcd_top
	import dmcd_pkg::*;
(
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	input  wire logic [`DMCD_ADDR_W-1:0]     avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest,
	input  wire logic                        frame_start,
	input  wire logic                        scroll_enter,
	input  wire logic [`DMCD_PIX_W-1:0]      mem_pixel,
	output logic      [`DMCD_PIX_W-1:0]      panel_pixel,
	output dmcd_mode_type                    mode,
	output logic      [`DMCD_ROW_W-1:0]      region_row_start,
	output logic      [`DMCD_ROW_W-1:0]      region_row_end
);

	// ------------------------------------------------------------
	// Address decode.
	// ------------------------------------------------------------

	logic                     sel_cmd;
	logic                     sel_par;
	logic                     sel_st;
	logic                     sel_area;

	always_comb begin
		sel_cmd  = 1'b0;
		sel_par  = 1'b0;
		sel_st   = 1'b0;
		sel_area = 1'b0;
		if (avs_address == `DMCD_OFS_CMD) begin
			sel_cmd = 1'b1;
		end else if (avs_address == `DMCD_OFS_PARAM) begin
			sel_par = 1'b1;
		end else if (avs_address == `DMCD_OFS_STATUS) begin
			sel_st = 1'b1;
		end else if (avs_address == `DMCD_OFS_AREA) begin
			sel_area = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Bus handshake.
	// ------------------------------------------------------------

	logic                     ack_q;
	logic                     req;
	logic                     take;
	logic                     cmd_wr;
	logic                     par_wr;
	logic [7:0]               wr_byte;
	logic [31:0]              rd_d;
	logic [31:0]              rd_q;

	assign req             = avs_read | avs_write;
	assign take            = req & ack_q;
	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata    = rd_q;
	assign wr_byte         = avs_writedata[7:0];

	// A write to the command word is a command phase, the parameter word a data phase.
	assign cmd_wr = take & avs_write & avs_byteenable[0] & sel_cmd;
	assign par_wr = take & avs_write & avs_byteenable[0] & sel_par;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// ------------------------------------------------------------
	// Command decode.
	// ------------------------------------------------------------

	logic                     sw_reset;
	logic                     is_partial;
	logic                     is_full;
	logic                     is_inv_clr;
	logic                     is_inv_set;
	logic                     is_area;

	assign sw_reset   = cmd_wr & (wr_byte == `DMCD_CMD_SWRESET);
	assign is_partial = cmd_wr & (wr_byte == `DMCD_CMD_PARTIAL);
	assign is_full    = cmd_wr & (wr_byte == `DMCD_CMD_FULL);
	assign is_inv_clr = cmd_wr & (wr_byte == `DMCD_CMD_INV_CLR);
	assign is_inv_set = cmd_wr & (wr_byte == `DMCD_CMD_INV_SET);
	assign is_area    = cmd_wr & (wr_byte == `DMCD_CMD_AREA);

	// ------------------------------------------------------------
	// Partial and normal mode, applied at frame start.
	// ------------------------------------------------------------

	logic                     want_partial_q;
	logic                     pend_q;
	logic                     partial_q;
	logic                     scroll_q;
	logic                     part_req;
	logic                     full_req;

	// A request that matches the mode already commanded does nothing, except a normal mode request while the scroll flag is set.
	assign part_req = is_partial & ~want_partial_q;
	assign full_req = is_full & (want_partial_q | scroll_q);

	always_ff @(posedge core_clk) begin
		if (!rst_n || sw_reset) begin
			want_partial_q <= 1'b0;
		end else if (part_req) begin
			want_partial_q <= 1'b1;
		end else if (full_req) begin
			want_partial_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || sw_reset) begin
			pend_q <= 1'b0;
		end else if (part_req || full_req) begin
			pend_q <= 1'b1;
		end else if (frame_start) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || sw_reset) begin
			partial_q <= 1'b0;
		end else if (frame_start && pend_q) begin
			partial_q <= want_partial_q;
		end
	end

	// The scroll flag is raised by the scroll logic and dropped by normal mode.
	always_ff @(posedge core_clk) begin
		if (!rst_n || sw_reset) begin
			scroll_q <= 1'b0;
		end else if (frame_start && pend_q && !want_partial_q) begin
			scroll_q <= 1'b0;
		end else if (scroll_enter) begin
			scroll_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Inversion, acting on the panel path only.
	// ------------------------------------------------------------

	logic                     invert_q;
	logic [`DMCD_PIX_W-1:0]   pixel_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n || sw_reset) begin
			invert_q <= 1'b0;
		end else if (is_inv_set && !invert_q) begin
			invert_q <= 1'b1;
		end else if (is_inv_clr && invert_q) begin
			invert_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Pixel path to the panel.
	// ------------------------------------------------------------

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pixel_q <= '0;
		end else if (invert_q) begin
			pixel_q <= ~mem_pixel;
		end else begin
			pixel_q <= mem_pixel;
		end
	end

	// The memory side is only read here, never written back.
	assign panel_pixel = pixel_q;

	// ------------------------------------------------------------
	// Partial area parameters.
	// ------------------------------------------------------------

	dmcd_state_type           st_q;
	logic [`DMCD_ROW_W-1:0]   area_start_q;
	logic [`DMCD_ROW_W-1:0]   area_end_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n || sw_reset) begin
			st_q <= DMCD_IDLE;
		end else if (cmd_wr) begin
			st_q <= is_area ? DMCD_PA1 : DMCD_IDLE;
		end else if (par_wr) begin
			case (st_q)
				DMCD_PA1: begin
					st_q <= DMCD_PA2;
				end
				DMCD_PA2: begin
					st_q <= DMCD_PA3;
				end
				DMCD_PA3: begin
					st_q <= DMCD_PA4;
				end
				default: begin
					st_q <= DMCD_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Partial area rows.
	// ------------------------------------------------------------

	always_ff @(posedge core_clk) begin
		if (!rst_n || sw_reset) begin
			area_start_q <= `DMCD_AREA_START_RST;
		end else if (par_wr) begin
			case (st_q)
				DMCD_PA1: begin
					area_start_q[15:8] <= wr_byte;
				end
				DMCD_PA2: begin
					area_start_q[7:0] <= wr_byte;
				end
				default: begin
					area_start_q <= area_start_q;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || sw_reset) begin
			area_end_q <= `DMCD_AREA_END_RST;
		end else if (par_wr) begin
			case (st_q)
				DMCD_PA3: begin
					area_end_q[15:8] <= wr_byte;
				end
				DMCD_PA4: begin
					area_end_q[7:0] <= wr_byte;
				end
				default: begin
					area_end_q <= area_end_q;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Outputs to the scan logic.
	// ------------------------------------------------------------

	logic [`DMCD_ROW_W-1:0]   rs_q;
	logic [`DMCD_ROW_W-1:0]   re_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rs_q <= `DMCD_AREA_START_RST;
		end else if (partial_q) begin
			rs_q <= area_start_q;
		end else begin
			rs_q <= `DMCD_AREA_START_RST;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			re_q <= `DMCD_AREA_END_RST;
		end else if (partial_q) begin
			re_q <= area_end_q;
		end else begin
			re_q <= `DMCD_AREA_END_RST;
		end
	end

	assign region_row_start = rs_q;
	assign region_row_end   = re_q;

	// ------------------------------------------------------------
	// Mode flags to the scan logic.
	// ------------------------------------------------------------

	assign mode.partial     = partial_q;
	assign mode.scroll      = scroll_q;
	assign mode.invert      = invert_q;

	// ------------------------------------------------------------
	// Read data.
	// ------------------------------------------------------------

	always_comb begin
		rd_d = `DMCD_ZERO32;
		if (sel_st) begin
			rd_d[`DMCD_ST_PARTIAL]   = partial_q;
			rd_d[`DMCD_ST_SCROLL]    = scroll_q;
			rd_d[`DMCD_ST_INVERT]    = invert_q;
			rd_d[`DMCD_ST_PEND_PART] = want_partial_q;
			rd_d[`DMCD_ST_PEND_CHG]  = pend_q;
		end else if (sel_area) begin
			rd_d = {area_end_q, area_start_q};
		end
	end

	// ------------------------------------------------------------
	// Read data register.
	// ------------------------------------------------------------

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rd_q <= `DMCD_ZERO32;
		end else if (avs_read && !ack_q) begin
			rd_q <= rd_d;
		end
	end

endmodule

// file: verification/dmcd_checker.sv
// Port assertions for the display mode command decoder.
`timescale 1ns/1ns
`include "dmcd_defines.svh"
module dmcd_checker
	import dmcd_pkg::*;
(
	input wire logic		core_clk,
	input wire logic		rst_n,
	input wire logic [3:0]		avs_address,
	input wire logic		avs_read,
	input wire logic		avs_write,
	input wire logic [31:0]		avs_writedata,
	input wire logic [3:0]		avs_byteenable,
	input wire logic [31:0]		avs_readdata,
	input wire logic		avs_waitrequest,
	input wire logic		frame_start,
	input wire logic		scroll_enter,
	input wire logic [17:0]		mem_pixel,
	input wire logic [17:0]		panel_pixel,
	input wire dmcd_mode_type	mode,
	input wire logic [15:0]		region_row_start,
	input wire logic [15:0]		region_row_end
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic	tk;
	assign tk = avs_write & ~avs_waitrequest & (avs_address == 4'h0) & avs_byteenable[0];
	property p_pix; 1 |=> panel_pixel == ($past(mem_pixel) ^ {18{$past(mode.invert)}}); endproperty
	a_pix: assert property (p_pix) else $error("panel pixel wrong");
	property p_hold; !frame_start && !tk |=> $stable(mode.partial); endproperty
	a_hold: assert property (p_hold) else $error("partial moved off frame start");
	property p_only; tk && avs_writedata[7:1] == 7'h10 && !frame_start && !scroll_enter
		|=> $stable({mode.partial, mode.scroll}); endproperty
	a_only: assert property (p_only) else $error("inversion touched other flags");
	property p_clr; tk && avs_writedata[7:0] == 8'h20 |=> !mode.invert; endproperty
	a_clr: assert property (p_clr) else $error("inversion not cleared");
	property p_set; tk && avs_writedata[7:0] == 8'h21 |=> mode.invert; endproperty
	a_set: assert property (p_set) else $error("inversion not set");
	property p_drop; $fell(mode.partial) |-> !mode.scroll; endproperty
	a_drop: assert property (p_drop) else $error("scroll kept in normal mode");
	property p_rise; $rose(mode.partial) |-> $past(frame_start); endproperty
	a_rise: assert property (p_rise) else $error("partial rose off frame start");
	property p_fall; $fell(mode.partial) |-> $past(frame_start) || $past(tk); endproperty
	a_fall: assert property (p_fall) else $error("partial fell without cause");
	property p_reg; !mode.partial |=> region_row_start == 16'h0000 &&
		region_row_end == `DMCD_AREA_END_RST; endproperty
	a_reg: assert property (p_reg) else $error("region not full screen");
	property p_rst; $rose(rst_n) |-> mode == 3'h0 && panel_pixel == 18'h0_0000; endproperty
	a_rst: assert property (p_rst) else $error("state after reset wrong");
endmodule

// file: verification/dmcd_host.sv
// Host model that issues register cycles.
`timescale 1ns/1ns
module dmcd_host (
	input wire logic		core_clk,
	input wire logic		avs_waitrequest,
	input wire logic [31:0]		avs_readdata,
	output logic [3:0]		avs_address,
	output logic			avs_read,
	output logic			avs_write,
	output logic [31:0]		avs_writedata,
	output logic [3:0]		avs_byteenable
);
	initial begin
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hf;
	end
	task automatic xfer(input logic rd, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= !rd;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
endmodule

// file: verification/testbench.sv
// Self-checking bench for the display mode command decoder.
`timescale 1ns/1ns
module testbench
	import dmcd_pkg::*;
;
	logic		core_clk, rst_n, frame_start, scroll_enter, avs_read, avs_write, avs_waitrequest;
	logic [3:0]	avs_address, avs_byteenable;
	logic [31:0]	avs_writedata, avs_readdata, rdq, seed;
	logic [17:0]	mem_pixel, panel_pixel, last_mem;
	logic [15:0]	region_row_start, region_row_end;
	logic [7:0]	inv_seq [4] = '{8'h21, 8'h21, 8'h20, 8'h20};
	dmcd_mode_type	mode;
	int		fail_count, comparisons, m_part, m_cmd, m_scr, m_inv, m_clr, m_rs, m_re;
	dmcd_top i_dmcd_top(.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .frame_start(frame_start), .scroll_enter(scroll_enter),
		.mem_pixel(mem_pixel), .panel_pixel(panel_pixel), .mode(mode),
		.region_row_start(region_row_start), .region_row_end(region_row_end));
	dmcd_host i_dmcd_host(.core_clk(core_clk), .avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	always @(posedge core_clk) begin
		seed = xs(seed);
		last_mem <= mem_pixel;
		mem_pixel <= seed[17:0];
	end
	task clr();
		{m_part, m_cmd, m_scr, m_inv, m_clr, m_rs} = '0;
		m_re = 16'h00A1;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] c);
		i_dmcd_host.xfer(1'b0, a, {24'h00_0000, c}, rdq);
		if (a == 4'h0 && c == 8'h12) m_cmd = 1;
		if (a == 4'h0 && c == 8'h13) {m_cmd, m_clr} = {32'd0, 32'd1};
		if (a == 4'h0 && c[7:1] == 7'h10) m_inv = c[0];
		if (a == 4'h0 && c == 8'h01) clr();
	endtask
	task pulse(input logic f);
		@(posedge core_clk);
		frame_start <= f;
		scroll_enter <= !f;
		@(posedge core_clk);
		frame_start <= 1'b0;
		scroll_enter <= 1'b0;
		m_scr = f ? (m_clr ? 0 : m_scr) : 1;
		m_part = f ? m_cmd : m_part;
		m_clr = f ? 0 : m_clr;
	endtask
	task chk();
		@(posedge core_clk);
		@(negedge core_clk);
		cmp({29'h0, mode}, {29'h0, m_part[0], m_scr[0], m_inv[0]});
		cmp({14'h0, panel_pixel}, {14'h0, last_mem ^ {18{m_inv[0]}}});
		cmp({region_row_end, region_row_start}, m_part ? {m_re[15:0], m_rs[15:0]} : 32'h00A1_0000);
		i_dmcd_host.xfer(1'b1, 4'h8, 32'h0000_0000, rdq);
		cmp(rdq & 32'h0000_000F, {28'h0, m_cmd[0], m_inv[0], m_scr[0], m_part[0]});
	endtask
	task wrap_up();
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		wrap_up();
	end
	initial begin
		{rst_n, frame_start, scroll_enter, mem_pixel, last_mem} = '0;
		seed = 32'h2dfb_149f;
		clr();
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		chk();
		wr(4'h0, 8'h30);
		for (int i = 0; i < 4; i++) wr(4'h4, {4'h0, i[0] ? 4'(i * 2 + 3) : 4'h0});
		{m_rs, m_re} = {32'd5, 32'd9};
		wr(4'h0, 8'h12);
		chk();
		pulse(1'b1);
		chk();
		wr(4'h0, 8'h12);
		pulse(1'b1);
		chk();
		pulse(1'b0);
		wr(4'h0, 8'h13);
		chk();
		pulse(1'b1);
		chk();
		wr(4'h0, 8'h13);
		pulse(1'b1);
		chk();
		wr(4'h0, 8'h12);
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, inv_seq[i]);
			chk();
		end
		pulse(1'b1);
		wr(4'h0, 8'h21);
		wr(4'h0, 8'h01);
		chk();
		wr(4'h0, 8'h21);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		clr();
		chk();
		wrap_up();
	end
endmodule
bind dmcd_top dmcd_checker i_dmcd_checker(.core_clk(core_clk), .rst_n(rst_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .frame_start(frame_start), .scroll_enter(scroll_enter),
	.mem_pixel(mem_pixel), .panel_pixel(panel_pixel), .mode(mode),
	.region_row_start(region_row_start), .region_row_end(region_row_end));
